// >>> hdl/fieldbus_cmd_handler.sv
// Purpose: Executes setup, fault read and fault clear commands held in an APB-written frame.
// Assumes: Fault and link events come from mclk logic as one-cycle pulses.
// Notes: The answer frame is rebuilt whole for every command; unused bytes read as zero.
//
// Register access over APB and the placing of the registers were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
module fieldbus_cmd_handler import fieldbus_cmd_pkg::*; #(
   parameter int HIST_DEPTH = HIST_DEPTH_DEF,
   parameter int SETUP_CYC = SETUP_CYCLES
) (
   input wire logic mclk,
   input wire logic reset_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic fault_event,
   input wire logic fault_is_warning,
   input wire logic [FAULT_CODE_W-1:0] fault_code,
   input wire logic link_fault_event,
   input wire logic [3:0] link_fault_code,
   output logic command_ready_flag,
   output logic [3:0] link_error_code,
   output logic setup_apply
);
   fieldbus_aux_if aux ();

   fault_history #(.DEPTH(HIST_DEPTH)) u_history (
      .mclk(mclk),
      .reset_n(reset_n),
      .fault_event(fault_event),
      .fault_code(fault_code),
      .aux(aux.history)
   );

   setup_engine #(.CYCLES(SETUP_CYC)) u_setup (
      .mclk(mclk),
      .reset_n(reset_n),
      .setup_apply(setup_apply),
      .aux(aux.setup)
   );

   state_type state_q, state_d;
   logic [7:0] cmd_q [FRAME_BYTES];
   logic [7:0] cmd_d [FRAME_BYTES];
   logic [7:0] rsp_q [FRAME_BYTES];
   logic [7:0] rsp_d [FRAME_BYTES];
   logic [1:0] phase_q, phase_d;
   logic device_fault_flag_q, device_fault_flag_d;
   logic device_warning_flag_q, device_warning_flag_d;
   logic [3:0] link_err_q, link_err_d;
   logic [3:0] cmd_err_q, cmd_err_d;
   logic [7:0] wdog_q, wdog_d;
   logic [3:0] fill_q, fill_d;
   logic [15:0] index_q, index_d;
   logic [31:0] prdata_q, prdata_d;
   logic wr_access;
   logic go;
   logic bus_err;
   logic phase_ok;
   logic [16:0] rd_sum;

   function automatic logic [15:0] status_word(input logic ready, input logic fault, input logic warn,
                                               input logic [3:0] link_err, input logic [3:0] cmd_err);
      logic [15:0] w;
      w = '0;
      w[STAT_CMD_ERR_LSB +: 4] = cmd_err;
      w[STAT_LINK_ERR_LSB +: 4] = link_err;
      w[STAT_FAULT_BIT] = fault;
      w[STAT_WARN_BIT] = warn;
      w[STAT_READY_BIT] = ready;
      return w;
   endfunction : status_word

   assign wr_access = psel && penable && pwrite;
   assign phase_ok = (phase_q == 2'h2) || (phase_q == 2'h3);
   assign rd_sum = {1'b0, index_q} + {13'h0000, fill_q};
   assign aux.rd_index = (rd_sum >= 17'(HIST_DEPTH)) ? '1 : rd_sum[HIST_IDX_W:0];

   always_comb
   begin
      logic [15:0] stat;
      logic [7:0] op;
      stat = '0;
      op = cmd_q[BYTE_OPCODE];
      state_d = state_q;
      cmd_d = cmd_q;
      rsp_d = rsp_q;
      phase_d = phase_q;
      device_fault_flag_d = device_fault_flag_q;
      device_warning_flag_d = device_warning_flag_q;
      link_err_d = link_err_q;
      cmd_err_d = cmd_err_q;
      wdog_d = wdog_q;
      fill_d = fill_q;
      index_d = index_q;
      prdata_d = prdata_q;
      go = 1'b0;
      bus_err = 1'b0;
      aux.setup_start = 1'b0;

      // Register writes; the command frame is locked while a command runs.
      if (psel && paddr[1:0] != 2'b00)
      begin
         bus_err = 1'b1;
      end
      else if (paddr < ADDR_RSP_BASE)
      begin
         if (wr_access && state_q == ST_IDLE)
         begin
            for (int b = 0; b < 4; b++)
            begin
               if (pstrb[b])
               begin
                  cmd_d[{paddr[4:2], 2'(b)}] = pwdata[8*b +: 8];
               end
            end
         end
         else if (psel && pwrite)
         begin
            bus_err = 1'b1;
         end
      end
      else if (paddr < ADDR_CTRL)
      begin
         bus_err = psel && pwrite;
      end
      else if (paddr == ADDR_CTRL)
      begin
         if (wr_access && pstrb[0] && pwdata[CTRL_GO_BIT])
         begin
            go = (state_q == ST_IDLE);
            bus_err = (state_q != ST_IDLE);
         end
      end
      else if (paddr == ADDR_PHASE)
      begin
         if (wr_access && pstrb[0])
         begin
            phase_d = pwdata[1:0];
         end
      end
      else if (paddr == ADDR_STATUS)
      begin
         bus_err = psel && pwrite;
      end
      else
      begin
         bus_err = psel;
      end

      // Read data is captured in the setup cycle so it comes from a flip-flop.
      if (psel && !penable)
      begin
         prdata_d = '0;
         if (paddr < ADDR_RSP_BASE)
         begin
            prdata_d = {cmd_q[{paddr[4:2], 2'd3}], cmd_q[{paddr[4:2], 2'd2}],
                        cmd_q[{paddr[4:2], 2'd1}], cmd_q[{paddr[4:2], 2'd0}]};
         end
         else if (paddr < ADDR_CTRL)
         begin
            prdata_d = {rsp_q[{paddr[4:2], 2'd3}], rsp_q[{paddr[4:2], 2'd2}],
                        rsp_q[{paddr[4:2], 2'd1}], rsp_q[{paddr[4:2], 2'd0}]};
         end
         else if (paddr == ADDR_PHASE)
         begin
            prdata_d = {30'h00000000, phase_q};
         end
         else if (paddr == ADDR_STATUS)
         begin
            prdata_d = {16'h0000, status_word(state_q == ST_IDLE, device_fault_flag_q,
                                             device_warning_flag_q, link_err_q, cmd_err_q)};
         end
      end

      case (state_q)
         ST_IDLE:
         begin
            if (go)
            begin
               for (int i = 0; i < FRAME_BYTES; i++)
               begin
                  rsp_d[i] = 8'h00;
               end
               rsp_d[BYTE_OPCODE] = op;
               wdog_d = wdog_q + 8'h01;
               cmd_err_d = CMD_ERR_NONE;
               state_d = ST_FINISH;
               case (op)
                  OP_SETUP:
                  begin
                     rsp_d[BYTE_MODE] = cmd_q[BYTE_MODE];
                     if (!phase_ok)
                     begin
                        cmd_err_d = CMD_ERR_PHASE;
                     end
                     else if (cmd_q[BYTE_MODE] != 8'h00)
                     begin
                        cmd_err_d = CMD_ERR_PARAM;
                     end
                     else
                     begin
                        aux.setup_start = 1'b1;
                        state_d = ST_SETUP;
                     end
                  end
                  OP_FAULT_READ:
                  begin
                     rsp_d[BYTE_MODE] = cmd_q[BYTE_MODE];
                     rsp_d[BYTE_INDEX_LO] = cmd_q[BYTE_INDEX_LO];
                     rsp_d[BYTE_INDEX_HI] = cmd_q[BYTE_INDEX_HI];
                     index_d = {cmd_q[BYTE_INDEX_HI], cmd_q[BYTE_INDEX_LO]};
                     fill_d = '0;
                     if (!phase_ok)
                     begin
                        cmd_err_d = CMD_ERR_PHASE;
                     end
                     else if (cmd_q[BYTE_MODE] != 8'h00 ||
                              {cmd_q[BYTE_INDEX_HI], cmd_q[BYTE_INDEX_LO]} >= 16'(HIST_DEPTH))
                     begin
                        cmd_err_d = CMD_ERR_PARAM;
                     end
                     else
                     begin
                        state_d = ST_FILL;
                     end
                  end
                  OP_FAULT_CLEAR:
                  begin
                     rsp_d[BYTE_MODE] = cmd_q[BYTE_MODE];
                     if (!phase_ok)
                     begin
                        cmd_err_d = CMD_ERR_PHASE;
                     end
                     else if (cmd_q[BYTE_MODE] != 8'h00)
                     begin
                        cmd_err_d = CMD_ERR_PARAM;
                     end
                     else
                     begin
                        link_err_d = 4'h0;
                     end
                  end
                  default:
                  begin
                     cmd_err_d = CMD_ERR_OPCODE;
                  end
               endcase
            end
         end
         ST_SETUP:
         begin
            if (aux.setup_done)
            begin
               state_d = ST_FINISH;
            end
         end
         ST_FILL:
         begin
            rsp_d[BYTE_DATA + 2 * int'(fill_q)] = aux.rd_code[7:0];
            rsp_d[BYTE_DATA + 2 * int'(fill_q) + 1] = aux.rd_code[15:8];
            fill_d = fill_q + 4'h1;
            if (int'(fill_q) == DATA_CODES - 1)
            begin
               state_d = ST_FINISH;
            end
         end
         ST_FINISH:
         begin
            stat = status_word(1'b1, device_fault_flag_q, device_warning_flag_q, link_err_q, cmd_err_q);
            rsp_d[BYTE_WDOG] = wdog_q;
            rsp_d[BYTE_STAT_LO] = stat[7:0];
            rsp_d[BYTE_STAT_HI] = stat[15:8];
            state_d = ST_IDLE;
         end
         default:
         begin
            state_d = ST_IDLE;
         end
      endcase

      // Events are applied last so a new one wins over a clear in the same cycle.
      if (fault_event)
      begin
         if (fault_is_warning)
         begin
            device_warning_flag_d = 1'b1;
         end
         else
         begin
            device_fault_flag_d = 1'b1;
         end
      end
      if (link_fault_event)
      begin
         link_err_d = link_fault_code;
      end
   end

   always_ff @(posedge mclk)
   begin
      if (!reset_n)
      begin
         state_q <= ST_IDLE;
         for (int i = 0; i < FRAME_BYTES; i++)
         begin
            cmd_q[i] <= 8'h00;
            rsp_q[i] <= 8'h00;
         end
         phase_q <= PHASE_RESET;
         device_fault_flag_q <= 1'b0;
         device_warning_flag_q <= 1'b0;
         link_err_q <= 4'h0;
         cmd_err_q <= CMD_ERR_NONE;
         wdog_q <= WDOG_RESET;
         fill_q <= 4'h0;
         index_q <= 16'h0000;
         prdata_q <= 32'h00000000;
      end
      else
      begin
         state_q <= state_d;
         cmd_q <= cmd_d;
         rsp_q <= rsp_d;
         phase_q <= phase_d;
         device_fault_flag_q <= device_fault_flag_d;
         device_warning_flag_q <= device_warning_flag_d;
         link_err_q <= link_err_d;
         cmd_err_q <= cmd_err_d;
         wdog_q <= wdog_d;
         fill_q <= fill_d;
         index_q <= index_d;
         prdata_q <= prdata_d;
      end
   end

   assign prdata = prdata_q;
   assign pready = 1'b1;
   assign pslverr = psel && penable && bus_err;
   assign command_ready_flag = state_q[0];
   assign link_error_code = link_err_q;
endmodule : fieldbus_cmd_handler
`default_nettype wire

// >>> hdl/fieldbus_cmd_pkg.sv
// Purpose: Constants and types for the fieldbus setup and fault command handler.
// Assumes: 32-byte command and response frames reach the handler over APB.
// Notes: How it works
// How it works
// - A setup command (04h) answers with its opcode and setup mode byte echoed and command ready shown as 1.
// - An unsupported setup mode gives command error code 9.
// - Setup mode zero starts a parameter recalculation and applies the new setup.
// - Command ready is 1 before setup, 0 while it runs and 1 afterwards, and the fault flags keep their state.
// - Setup, fault read and fault clear are only accepted in phases 2 and 3; in other phases they give command error code 10.
// - A fault read (05h) echoes opcode, read mode and history index, and completes with command ready 1.
// - The fault read answer holds the index in bytes 6 and 7 and stored fault codes in bytes 8 to 31.
// - An invalid read mode or history index in a fault read gives command error code 9.
// - Read mode zero returns the present fault and warning codes.
// - History index zero selects the latest fault or warning.
// - A fault clear (06h) resets only the link error; device faults and warnings stay until power is cycled.
// - An invalid clear mode gives command error code 9.
package fieldbus_cmd_pkg;
   localparam int FRAME_BYTES = 32;
   localparam int FAULT_CODE_W = 16;
   localparam int HIST_IDX_W = 4;
   localparam int HIST_DEPTH_DEF = 16;
   localparam int DATA_CODES = 12;

   localparam logic [7:0] OP_SETUP = 8'h04;
   localparam logic [7:0] OP_FAULT_READ = 8'h05;
   localparam logic [7:0] OP_FAULT_CLEAR = 8'h06;

   localparam int BYTE_OPCODE = 0;
   localparam int BYTE_WDOG = 1;
   localparam int BYTE_STAT_LO = 2;
   localparam int BYTE_STAT_HI = 3;
   localparam int BYTE_MODE = 4;
   localparam int BYTE_INDEX_LO = 6;
   localparam int BYTE_INDEX_HI = 7;
   localparam int BYTE_DATA = 8;

   localparam logic [3:0] CMD_ERR_NONE = 4'h0;
   localparam logic [3:0] CMD_ERR_OPCODE = 4'h8;
   localparam logic [3:0] CMD_ERR_PARAM = 4'h9;
   localparam logic [3:0] CMD_ERR_PHASE = 4'hA;

   // Status word layout, also sent in response bytes 2 and 3.
   localparam int STAT_CMD_ERR_LSB = 0;
   localparam int STAT_LINK_ERR_LSB = 4;
   localparam int STAT_FAULT_BIT = 8;
   localparam int STAT_WARN_BIT = 9;
   localparam int STAT_READY_BIT = 10;

   localparam logic [7:0] ADDR_CMD_BASE = 8'h00;
   localparam logic [7:0] ADDR_RSP_BASE = 8'h20;
   localparam logic [7:0] ADDR_CTRL = 8'h40;
   localparam logic [7:0] ADDR_PHASE = 8'h44;
   localparam logic [7:0] ADDR_STATUS = 8'h48;
   localparam int CTRL_GO_BIT = 0;

   localparam logic [1:0] PHASE_RESET = 2'h1;
   localparam logic [7:0] WDOG_RESET = 8'h00;

   localparam int CLK_MHZ = 200;
   localparam int SETUP_TIME_NS = 2000;
   localparam int SETUP_CYCLES = (SETUP_TIME_NS * CLK_MHZ + 999) / 1000;

   typedef enum logic [3:0] {
      ST_IDLE = 4'b0001,
      ST_SETUP = 4'b0010,
      ST_FILL = 4'b0100,
      ST_FINISH = 4'b1000
   } state_type;
endpackage : fieldbus_cmd_pkg

// >>> hdl/fieldbus_aux_if.sv
// Purpose: Links the command handler to its setup engine and fault history.
// Assumes: All three parties run on mclk.
// Notes: rd_index at or beyond the stored count reads as code zero.
`timescale 1ns/100ps
`default_nettype none
interface fieldbus_aux_if import fieldbus_cmd_pkg::*; ();
   logic setup_start;
   logic setup_busy;
   logic setup_done;
   logic [HIST_IDX_W:0] rd_index;
   logic [FAULT_CODE_W-1:0] rd_code;
   modport handler (output setup_start, rd_index, input setup_busy, setup_done, rd_code);
   modport setup (input setup_start, output setup_busy, setup_done);
   modport history (input rd_index, output rd_code);
endinterface : fieldbus_aux_if
`default_nettype wire

// >>> hdl/fault_history.sv
// Purpose: Keeps the most recent fault and warning codes, newest at index zero.
// Assumes: fault_event is a one-cycle pulse from mclk logic.
// Notes: Only reset clears the history, as a power cycle would.
`timescale 1ns/100ps
`default_nettype none
module fault_history import fieldbus_cmd_pkg::*; #(
   parameter int DEPTH = HIST_DEPTH_DEF
) (
   input wire logic mclk,
   input wire logic reset_n,
   input wire logic fault_event,
   input wire logic [FAULT_CODE_W-1:0] fault_code,
   fieldbus_aux_if.history aux
);
   generate
      if (DEPTH < 2 || DEPTH > (1 << HIST_IDX_W))
      begin : g_bad_depth
         $error("fault_history DEPTH out of range");
      end
   endgenerate

   logic [FAULT_CODE_W-1:0] mem_q [DEPTH];
   logic [FAULT_CODE_W-1:0] mem_d [DEPTH];
   logic [HIST_IDX_W-1:0] wr_q, wr_d;
   logic [HIST_IDX_W:0] cnt_q, cnt_d;

   always_comb
   begin
      int slot;
      slot = 0;
      mem_d = mem_q;
      wr_d = wr_q;
      cnt_d = cnt_q;
      if (fault_event)
      begin
         mem_d[wr_q] = fault_code;
         wr_d = (int'(wr_q) == DEPTH - 1) ? '0 : wr_q + 1'b1;
         if (int'(cnt_q) < DEPTH)
         begin
            cnt_d = cnt_q + 1'b1;
         end
      end
      aux.rd_code = '0;
      if (aux.rd_index < cnt_q)
      begin
         slot = int'(wr_q) - 1 - int'(aux.rd_index);
         if (slot < 0)
         begin
            slot = slot + DEPTH;
         end
         aux.rd_code = mem_q[slot];
      end
   end

   always_ff @(posedge mclk)
   begin
      if (!reset_n)
      begin
         for (int i = 0; i < DEPTH; i++)
         begin
            mem_q[i] <= '0;
         end
         wr_q <= '0;
         cnt_q <= '0;
      end
      else
      begin
         mem_q <= mem_d;
         wr_q <= wr_d;
         cnt_q <= cnt_d;
      end
   end
endmodule : fault_history
`default_nettype wire

// >>> hdl/setup_engine.sv
// Purpose: Times the parameter recalculation and applies the new setup at its end.
// Assumes: setup_start is a one-cycle pulse given only while idle.
// Notes: setup_apply pulses in the same cycle as setup_done.
`timescale 1ns/100ps
`default_nettype none
module setup_engine import fieldbus_cmd_pkg::*; #(
   parameter int CYCLES = SETUP_CYCLES
) (
   input wire logic mclk,
   input wire logic reset_n,
   output logic setup_apply,
   fieldbus_aux_if.setup aux
);
   generate
      if (CYCLES < 1 || CYCLES > 65535)
      begin : g_bad_cycles
         $error("setup_engine CYCLES out of range");
      end
   endgenerate

   logic [15:0] cnt_q, cnt_d;

   always_comb
   begin
      cnt_d = cnt_q;
      if (aux.setup_start && cnt_q == '0)
      begin
         cnt_d = 16'(CYCLES);
      end
      else if (cnt_q != '0)
      begin
         cnt_d = cnt_q - 1'b1;
      end
      aux.setup_busy = (cnt_q != '0);
      aux.setup_done = (cnt_q == 16'h0001);
      setup_apply = aux.setup_done;
   end

   always_ff @(posedge mclk)
   begin
      if (!reset_n)
      begin
         cnt_q <= '0;
      end
      else
      begin
         cnt_q <= cnt_d;
      end
   end
endmodule : setup_engine
`default_nettype wire

// >>> tb/fieldbus_cmd_handler_sva.sv
// Purpose: Concurrent checks on the command handler ports.
// Assumes: One clock, mclk, with synchronous active low reset_n.
// Notes: Bound to every instance of the handler.
`timescale 1ns/100ps
`default_nettype none
module fieldbus_cmd_handler_sva import fieldbus_cmd_pkg::*; (
   input wire logic mclk,
   input wire logic reset_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic link_fault_event,
   input wire logic [3:0] link_fault_code,
   input wire logic command_ready_flag,
   input wire logic [3:0] link_error_code,
   input wire logic setup_apply
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!reset_n);
   sequence go_s;
      psel && penable && pwrite && paddr == ADDR_CTRL && pstrb[0] && pwdata[CTRL_GO_BIT];
   endsequence
   sequence ready_back_s;
      ##[1:1000] command_ready_flag;
   endsequence
   property reset_p;
      @(posedge mclk) disable iff (1'b0)
      !reset_n |=> command_ready_flag && link_error_code == 4'h0 && !setup_apply;
   endproperty
   a_access_ready: assert property (psel && penable |-> pready)
      else $error("access cycle without ready");
   a_err_in_access: assert property (pslverr |-> psel && penable)
      else $error("error outside access");
   a_bad_addr_err: assert property (psel && penable && (paddr[1:0] != 2'h0 || paddr > ADDR_STATUS)
      |-> pslverr && prdata == 32'h0)
      else $error("bad address not refused");
   a_resp_read_only: assert property (psel && penable && pwrite && (paddr == ADDR_STATUS ||
      (paddr >= ADDR_RSP_BASE && paddr < ADDR_CTRL)) |-> pslverr)
      else $error("read-only write accepted");
   a_go_drops_ready: assert property (go_s ##0 (command_ready_flag && !pslverr) |=> !command_ready_flag)
      else $error("ready stayed high after go");
   a_busy_go_err: assert property (go_s ##0 !command_ready_flag |-> pslverr)
      else $error("busy go accepted");
   a_ready_returns: assert property ($fell(command_ready_flag) |-> ready_back_s)
      else $error("ready did not return");
   a_apply_while_busy: assert property (setup_apply |-> !command_ready_flag ##1 !setup_apply)
      else $error("setup apply outside setup");
   a_link_code_load: assert property (link_fault_event |=> link_error_code == $past(link_fault_code))
      else $error("link error code not loaded");
   a_reset_values: assert property (reset_p)
      else $error("outputs wrong after reset");
endmodule : fieldbus_cmd_handler_sva
bind fieldbus_cmd_handler fieldbus_cmd_handler_sva u_sva (.mclk, .reset_n, .psel, .penable, .pwrite, .paddr,
   .pwdata, .pstrb, .prdata, .pready, .pslverr, .link_fault_event, .link_fault_code, .command_ready_flag,
   .link_error_code, .setup_apply);
`default_nettype wire

// >>> tb/fieldbus_master_model.sv
// Purpose: Network master issuing APB transfers and command frames.
// Assumes: Slave may answer after any number of cycles.
// Notes: After their blocking time-zero values, signals change only by non-blocking assignment after a rising edge.
`timescale 1ns/100ps
`default_nettype none
module fieldbus_master_model import fieldbus_cmd_pkg::*; (
   input wire logic mclk,
   output logic psel,
   output logic penable,
   output logic pwrite,
   output logic [7:0] paddr,
   output logic [31:0] pwdata,
   output logic [3:0] pstrb,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr
);
   initial
   begin
      {psel, penable, pwrite, paddr, pwdata} = '0;
      pstrb = 4'hF;
   end
   task automatic xfer(input logic wr, input logic [7:0] addr, input logic [31:0] wd,
      output logic [31:0] rd, output logic err);
      @(posedge mclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= addr;
      pwdata <= wd;
      @(posedge mclk);
      penable <= 1'b1;
      do @(posedge mclk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : xfer
   task automatic send_cmd(input logic [7:0] op, input logic [7:0] md, input logic [15:0] idx,
      input logic [1:0] ph);
      logic [31:0] d;
      logic e;
      int w;
      xfer(1'b1, ADDR_CMD_BASE, {16'h0000, WDOG_RESET, op}, d, e);
      xfer(1'b1, ADDR_CMD_BASE + 8'h04, {idx, 8'h00, md}, d, e);
      for (w = 2; w < 8; w++) xfer(1'b1, ADDR_CMD_BASE + 8'(4 * w), 32'h0, d, e);
      xfer(1'b1, ADDR_PHASE, {30'h0, ph}, d, e);
      xfer(1'b1, ADDR_CTRL, 32'h1, d, e);
   endtask : send_cmd
endmodule : fieldbus_master_model
`default_nettype wire

// >>> tb/fieldbus_cmd_handler_tb.sv
// Purpose: Self-checking bench for the command handler.
// Assumes: Short setup count of 5 cycles, history depth 16.
// Notes: Expected codes come from a local history copy.
`timescale 1ns/100ps
`default_nettype none
module fieldbus_cmd_handler_tb import fieldbus_cmd_pkg::*; ();
   localparam int SETUP_T = 5;
   localparam int HIST = 16;
   logic mclk, reset_n, psel, penable, pwrite, pready, pslverr, er;
   logic fault_event, fault_is_warning, link_fault_event, command_ready_flag, setup_apply, fault_seen, warn_seen;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [3:0] pstrb, link_fault_code, link_error_code, link_exp;
   logic [FAULT_CODE_W-1:0] fault_code;
   logic [15:0] hist[$];
   logic [31:0] rsp[8];
   logic [7:0] bad_addr[3] = '{8'h80, 8'h41, 8'h20};
   int n_fail, check_count, n_apply, seed, i;
   fieldbus_cmd_handler #(.HIST_DEPTH(HIST), .SETUP_CYC(SETUP_T)) u_fieldbus_cmd_handler (
      .mclk, .reset_n, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr,
      .fault_event, .fault_is_warning, .fault_code, .link_fault_event, .link_fault_code,
      .command_ready_flag, .link_error_code, .setup_apply);
   fieldbus_master_model u_fieldbus_master_model (.mclk, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
      .prdata, .pready, .pslverr);
   task automatic tally_and_finish();
      if (n_fail == 0 && check_count > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : tally_and_finish
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
      check_count++;
      if (got !== exp)
      begin
         $display("unexpected at %0t: %s got %h expected %h", $time, msg, got, exp);
         n_fail++;
      end
   endtask : chk
   function automatic logic [15:0] exp_stat(input logic [3:0] err);
      return {5'h00, 1'b1, warn_seen, fault_seen, link_exp, err};
   endfunction : exp_stat
   function automatic logic [15:0] exp_code(input int k);
      return (k < hist.size()) ? hist[k] : 16'h0000;
   endfunction : exp_code
   function automatic logic [31:0] exp_word(input logic [7:0] op, input logic [7:0] md, input logic [15:0] idx,
      input int w);
      if (w == 1)
         return {(op == OP_FAULT_READ) ? idx : 16'h0000, 8'h00, md};
      if (op != OP_FAULT_READ)
         return 32'h0;
      return {exp_code(int'(idx) + 2 * w - 3), exp_code(int'(idx) + 2 * w - 4)};
   endfunction : exp_word
   task automatic inject(input logic lnk, input logic warn);
      logic [15:0] c;
      c = 16'($random(seed));
      @(posedge mclk);
      if (lnk)
      begin
         link_fault_event <= 1'b1;
         link_fault_code <= c[3:0] | 4'h1;
         link_exp = c[3:0] | 4'h1;
      end
      else
      begin
         fault_event <= 1'b1;
         fault_is_warning <= warn;
         fault_code <= c;
         hist.push_front(c);
         fault_seen |= !warn;
         warn_seen |= warn;
      end
      @(posedge mclk);
      fault_event <= 1'b0;
      link_fault_event <= 1'b0;
      @(posedge mclk);
   endtask : inject
   task automatic do_cmd(input logic [7:0] op, input logic [7:0] md, input logic [15:0] idx,
      input logic [1:0] ph, input logic [3:0] err);
      logic [31:0] d;
      logic e;
      int w;
      n_apply = 0;
      u_fieldbus_master_model.send_cmd(op, md, idx, ph);
      if (op == OP_SETUP && err == CMD_ERR_NONE)
      begin
         u_fieldbus_master_model.xfer(1'b1, ADDR_CTRL, 32'h1, d, e);
         chk(32'(e), 32'h1, "start while busy");
      end
      do @(posedge mclk); while (command_ready_flag !== 1'b1);
      for (w = 0; w < 8; w++) u_fieldbus_master_model.xfer(1'b0, ADDR_RSP_BASE + 8'(4 * w), 32'h0, rsp[w], e);
      chk(rsp[0] & 32'hFFFF00FF, {exp_stat(err), 8'h00, op}, "opcode or status");
      if (err == CMD_ERR_NONE)
         for (w = 1; w < 8; w++) chk(rsp[w], exp_word(op, md, idx, w), "response body");
   endtask : do_cmd
   always @(posedge mclk) if (setup_apply === 1'b1) n_apply++;
   initial
   begin
      mclk = 1'b0;
      forever #2.5 mclk = ~mclk;
   end
   initial
   begin
      #200000;
      n_fail++;
      tally_and_finish();
   end
   initial
   begin
      seed = 32'h76FC3534;
      {reset_n, fault_event, fault_is_warning, link_fault_event, fault_seen, warn_seen, fault_code,
       link_fault_code, link_exp} = 30'h00000000;
      repeat (12) @(posedge mclk);
      reset_n <= 1'b1;
      u_fieldbus_master_model.xfer(1'b0, ADDR_STATUS, 32'h0, rd, er);
      chk(rd, 32'h00000400, "status after reset");
      u_fieldbus_master_model.xfer(1'b0, ADDR_PHASE, 32'h0, rd, er);
      chk(rd, 32'h00000001, "phase after reset");
      for (i = 0; i < 3; i++)
      begin
         u_fieldbus_master_model.xfer(i == 2, bad_addr[i], 32'hFFFFFFFF, rd, er);
         chk(32'(er), 32'h1, "bad access not refused");
      end
      do_cmd(OP_SETUP, 8'h00, 16'h0000, 2'h1, CMD_ERR_PHASE);
      chk(32'(n_apply), 32'h0, "setup applied in phase 1");
      for (i = 0; i < 5; i++) inject(1'b0, i == 3);
      do_cmd(OP_SETUP, 8'h00, 16'h0000, 2'h2, CMD_ERR_NONE);
      chk(32'(n_apply), 32'h1, "setup not applied");
      do_cmd(OP_SETUP, 8'($random(seed)) | 8'h01, 16'h0000, 2'h3, CMD_ERR_PARAM);
      chk(32'(n_apply), 32'h0, "bad setup applied");
      do_cmd(OP_FAULT_READ, 8'h00, 16'h0000, 2'h2, CMD_ERR_NONE);
      do_cmd(OP_FAULT_READ, 8'h00, 16'h0002, 2'h3, CMD_ERR_NONE);
      do_cmd(OP_FAULT_READ, 8'($random(seed)) | 8'h01, 16'h0000, 2'h2, CMD_ERR_PARAM);
      do_cmd(OP_FAULT_READ, 8'h00, 16'(HIST), 2'h2, CMD_ERR_PARAM);
      inject(1'b1, 1'b0);
      chk(32'(link_error_code), 32'(link_exp), "link code not loaded");
      do_cmd(OP_FAULT_CLEAR, 8'($random(seed)) | 8'h01, 16'h0000, 2'h3, CMD_ERR_PARAM);
      link_exp = 4'h0;
      do_cmd(OP_FAULT_CLEAR, 8'h00, 16'h0000, 2'h2, CMD_ERR_NONE);
      chk(32'(link_error_code), 32'h0, "link error not cleared");
      u_fieldbus_master_model.xfer(1'b0, ADDR_STATUS, 32'h0, rd, er);
      chk(rd, {16'h0000, exp_stat(CMD_ERR_NONE)}, "device flags lost");
      tally_and_finish();
   end
endmodule : fieldbus_cmd_handler_tb
`default_nettype wire
